//--- rtl/chfs_regs.sv
// Charger fault, throttle status and charge current registers behind a two-wire target port
//
// Contract
// - Bit 4 of the fault byte goes high on a system overvoltage.
// - The power converter stays disabled while a system overvoltage is present.
// - The overvoltage latch clears only on a zero written to bit 4 or on adapter removal.
// - Latch-off, reverse overvoltage and reverse overcurrent faults latch until read.
// - A read-only 16-bit throttle word at 22h/23h resets to zero, upper bits reserved.
// - The setpoint spans 64 mA to 8.128 A in 64 mA steps through a 7-bit field.
// - At power-on without automatic wakeup the setpoint is zero.
// - The setpoint clears when input good falls for any reason but input overvoltage.
// - The setpoint clears when the pack-present pin falls.
// - Input overcurrent, thermal shutdown, latch-off and overvoltage keep the setpoint.
// - Setpoint at 02h/03h, field in high bits 4:0 and low bits 7:6, reset zero.
// - Each setpoint field bit weighs from 4096 mA for bit 6 down to 64 mA for bit 0.
// - The input good used for clearing matches the input-present status bit.
module chfs_regs (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic system_overvoltage_i,
	input wire logic power_path_latchoff_i,
	input wire logic reverse_mode_overvoltage_fault_i,
	input wire logic reverse_mode_overcurrent_fault_i,
	input wire logic comparator_trip_i,
	input wire logic critical_current_i,
	input wire logic nominal_current_i,
	input wire logic discharge_current_i,
	input wire logic system_voltage_i,
	input wire logic pack_removal_i,
	input wire logic source_removal_i,
	input wire logic input_good_i,
	input wire logic input_overvoltage_i,
	input wire logic cell_count_pack_present_i,
	output logic converter_enable_o,
	output logic [12:0] charge_current_ma_o
);

	// ************************************************************
	// Pin synchronisation and edges
	// ************************************************************
	logic [15:0] pins_async;
	logic [15:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic ovp_s;
	logic [2:0] flt_s;
	logic [6:0] thr_s;
	logic ig_s;
	logic iov_s;
	logic pack_s;

	assign pins_async = {scl_i, sda_i, system_overvoltage_i, power_path_latchoff_i,
		reverse_mode_overvoltage_fault_i, reverse_mode_overcurrent_fault_i,
		comparator_trip_i, critical_current_i, nominal_current_i, discharge_current_i,
		system_voltage_i, pack_removal_i, source_removal_i,
		input_good_i, input_overvoltage_i, cell_count_pack_present_i};

	chfs_sync #(
		.WIDTH(16)
	) u_sync (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.async_i(pins_async),
		.sync_o(pins_s)
	);

	// Named slices of the synchronised pins
	assign scl_s = pins_s[15];
	assign sda_s = pins_s[14];
	assign ovp_s = pins_s[13];
	assign flt_s = pins_s[12:10];
	assign thr_s = pins_s[9:3];
	assign ig_s = pins_s[2];
	assign iov_s = pins_s[1];
	assign pack_s = pins_s[0];

	logic scl_prev_q, scl_prev_d, sda_prev_q, sda_prev_d;
	logic ig_prev_q, ig_prev_d, pack_prev_q, pack_prev_d;

	// Previous samples for edge detection
	always_comb
	begin
		scl_prev_d = scl_s;
		sda_prev_d = sda_s;
		ig_prev_d = ig_s;
		pack_prev_d = pack_s;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			scl_prev_q <= 1'b0;
			sda_prev_q <= 1'b0;
			ig_prev_q <= 1'b0;
			pack_prev_q <= 1'b0;
		end
		else
		begin
			scl_prev_q <= scl_prev_d;
			sda_prev_q <= sda_prev_d;
			ig_prev_q <= ig_prev_d;
			pack_prev_q <= pack_prev_d;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// ************************************************************
	// Sticky status flags
	// ************************************************************
	logic ovp_flag;
	logic ovp_clr;
	logic [2:0] flt_q;
	logic [6:0] thr_q;
	logic flt_rd_clr;
	logic thr_rd_clr;
	logic wr_stb;
	logic rd_load;
	logic [7:0] shreg_q;
	logic [7:0] ptr_q;

	// latch clear paths
	// A write of zero to the flag or a lost adapter clears it; a standing fault sets it again
	assign ovp_clr = (wr_stb && ptr_q == chfs_pkg::CHFS_OFS_FAULT
		&& !shreg_q[chfs_pkg::CHFS_OVP_BIT]) || !ig_s;

	chfs_flag u_ovp (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.set_i(ovp_s),
		.clr_i(ovp_clr),
		.flag_o(ovp_flag)
	);

	assign flt_rd_clr = rd_load && ptr_q == chfs_pkg::CHFS_OFS_FAULT;
	assign thr_rd_clr = rd_load && ptr_q == chfs_pkg::CHFS_OFS_THR_LO;

	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++)
		begin : g_flag
			logic flag_q;
			chfs_flag u_flag (
				.mclk_i(mclk_i),
				.rstn_i(rstn_i),
				.set_i(gi < 3 ? flt_s[gi % 3] : thr_s[(gi + 4) % 7]),
				.clr_i(gi < 3 ? flt_rd_clr : thr_rd_clr),
				.flag_o(flag_q)
			);
			if (gi < 3)
			begin : g_flt
				assign flt_q[gi] = flag_q;
			end
			else
			begin : g_thr
				assign thr_q[gi - 3] = flag_q;
			end
		end
	endgenerate

	// ************************************************************
	// Read data mux
	// ************************************************************
	logic [7:0] rd_byte;
	logic [chfs_pkg::CHFS_CUR_W-1:0] field_q, field_d;

	always_comb
	begin
		case (ptr_q)
			chfs_pkg::CHFS_OFS_FAULT: rd_byte = {3'h0, ovp_flag, 1'b0, flt_q};
			chfs_pkg::CHFS_OFS_STAT_HI: rd_byte = {ig_s, 7'h00};
			// throttle word, bit 7 and upper byte reserved
			chfs_pkg::CHFS_OFS_THR_LO: rd_byte = {1'b0, thr_q};
			chfs_pkg::CHFS_OFS_CUR_HI: rd_byte = {3'h0, field_q[6:2]};
			chfs_pkg::CHFS_OFS_CUR_LO: rd_byte = {field_q[1:0], 6'h00};
			default: rd_byte = chfs_pkg::CHFS_BYTE_RESET;
		endcase
	end

	// ************************************************************
	// Two-wire target sequencer
	// ************************************************************
	chfs_pkg::chfs_state_t state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] shreg_d, ptr_d;
	logic ptr_seen_q, ptr_seen_d, rw_q, rw_d, nack_q, nack_d, oe_q, oe_d;

	// Bits move on clock edges seen through the synchroniser; data changes after a falling edge
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		shreg_d = shreg_q;
		ptr_d = ptr_q;
		ptr_seen_d = ptr_seen_q;
		rw_d = rw_q;
		nack_d = nack_q;
		oe_d = oe_q;
		wr_stb = 1'b0;
		rd_load = 1'b0;
		if (bus_start)
		begin
			state_d = chfs_pkg::CHFS_ST_ADDR;
			cnt_d = 4'h0;
			ptr_seen_d = 1'b0;
			oe_d = 1'b0;
		end
		else if (bus_stop)
		begin
			state_d = chfs_pkg::CHFS_ST_IDLE;
			oe_d = 1'b0;
		end
		else
		begin
			case (state_q)
				chfs_pkg::CHFS_ST_IDLE:
				begin
					oe_d = 1'b0;
				end
				chfs_pkg::CHFS_ST_ADDR, chfs_pkg::CHFS_ST_WR:
				begin
					if (scl_rise)
					begin
						shreg_d = {shreg_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end
					else if (scl_fall && cnt_q == chfs_pkg::CHFS_BYTE_BITS)
					begin
						cnt_d = 4'h0;
						if (state_q == chfs_pkg::CHFS_ST_ADDR)
						begin
							rw_d = shreg_q[0];
							oe_d = shreg_q[7:1] == chfs_pkg::CHFS_DEV_ADDR;
							state_d = oe_d ? chfs_pkg::CHFS_ST_AACK : chfs_pkg::CHFS_ST_IDLE;
						end
						else
						begin
							// First data byte is the pointer, later ones write and advance
							wr_stb = ptr_seen_q;
							ptr_d = ptr_seen_q ? ptr_q + 8'h01 : shreg_q;
							ptr_seen_d = 1'b1;
							oe_d = 1'b1;
							state_d = chfs_pkg::CHFS_ST_WACK;
						end
					end
				end
				chfs_pkg::CHFS_ST_WACK:
				begin
					if (scl_fall)
					begin
						oe_d = 1'b0;
						state_d = chfs_pkg::CHFS_ST_WR;
					end
				end
				chfs_pkg::CHFS_ST_AACK, chfs_pkg::CHFS_ST_RACK:
				begin
					if (scl_rise)
						nack_d = sda_s && state_q == chfs_pkg::CHFS_ST_RACK;
					else if (scl_fall)
					begin
						cnt_d = 4'h0;
						if (state_q == chfs_pkg::CHFS_ST_AACK && !rw_q)
						begin
							oe_d = 1'b0;
							state_d = chfs_pkg::CHFS_ST_WR;
						end
						else if (nack_q)
						begin
							oe_d = 1'b0;
							state_d = chfs_pkg::CHFS_ST_IDLE;
						end
						else
						begin
							rd_load = 1'b1;
							shreg_d = rd_byte;
							oe_d = ~rd_byte[7];
							ptr_d = ptr_q + 8'h01;
							state_d = chfs_pkg::CHFS_ST_RD;
						end
					end
				end
				chfs_pkg::CHFS_ST_RD:
				begin
					if (scl_rise)
						cnt_d = cnt_q + 4'h1;
					else if (scl_fall && cnt_q == chfs_pkg::CHFS_BYTE_BITS)
					begin
						oe_d = 1'b0;
						cnt_d = 4'h0;
						state_d = chfs_pkg::CHFS_ST_RACK;
					end
					else if (scl_fall)
					begin
						shreg_d = {shreg_q[6:0], 1'b0};
						oe_d = ~shreg_q[6];
					end
				end
				default:
				begin
					state_d = chfs_pkg::CHFS_ST_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			state_q <= chfs_pkg::CHFS_ST_IDLE;
			cnt_q <= 4'h0;
			shreg_q <= chfs_pkg::CHFS_BYTE_RESET;
			ptr_q <= chfs_pkg::CHFS_BYTE_RESET;
			ptr_seen_q <= 1'b0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shreg_q <= shreg_d;
			ptr_q <= ptr_d;
			ptr_seen_q <= ptr_seen_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			oe_q <= oe_d;
		end
	end

	// ************************************************************
	// Charge current setpoint and converter control
	// ************************************************************
	logic [7:0] stage_q, stage_d;
	logic [12:0] ma_q, ma_d;
	logic conv_en_q, conv_en_d;
	logic cur_clear;
	logic cur_commit;

	// other faults have no path here
	assign cur_clear = (ig_prev_q && !ig_s && !iov_s) || (pack_prev_q && !pack_s);
	// high byte write with reserved bits clear
	assign cur_commit = wr_stb && ptr_q == chfs_pkg::CHFS_OFS_CUR_HI
		&& shreg_q[7:5] == chfs_pkg::CHFS_CUR_HI_RSV_OK;

	// Low byte is staged and the field changes only on the high byte, so no half update shows
	always_comb
	begin
		stage_d = stage_q;
		field_d = field_q;
		if (wr_stb && ptr_q == chfs_pkg::CHFS_OFS_CUR_LO)
			stage_d = shreg_q;
		if (cur_commit)
			field_d = {shreg_q[4:0], stage_q[7:chfs_pkg::CHFS_CUR_LO_LSB]};
		if (cur_clear)
			field_d = chfs_pkg::CHFS_CUR_RESET;
		ma_d = {6'h00, field_q} * chfs_pkg::CHFS_CUR_STEP_MA;
		conv_en_d = !(ovp_flag || ovp_s);
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			stage_q <= chfs_pkg::CHFS_BYTE_RESET;
			field_q <= chfs_pkg::CHFS_CUR_RESET;
			ma_q <= '0;
			conv_en_q <= 1'b0;
		end
		else
		begin
			stage_q <= stage_d;
			field_q <= field_d;
			ma_q <= ma_d;
			conv_en_q <= conv_en_d;
		end
	end

	// Open-drain data pin only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_q;
	assign converter_enable_o = conv_en_q;
	assign charge_current_ma_o = ma_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);

	ovp_flag_set_a: assert property (ovp_s |=> ovp_flag)
		else $error("overvoltage flag not set");
	conv_held_off_a: assert property (ovp_s |=> ##1 !converter_enable_o)
		else $error("converter enabled during overvoltage");
	ovp_latch_hold_a: assert property (ovp_flag && !ovp_clr |=> ovp_flag)
		else $error("overvoltage latch dropped without clear");
	fault_held_a: assert property (flt_q[0] && !flt_rd_clr |=> flt_q[0])
		else $error("fault dropped before read");
	thr_reserved_a: assert property (rd_load && ptr_q == chfs_pkg::CHFS_OFS_THR_HI
		|=> shreg_q == 8'h00)
		else $error("reserved throttle byte not zero");
	thr_trigger_a: assert property (thr_s[6] |=> (thr_q[6] && rd_byte[6])
		|| ptr_q != chfs_pkg::CHFS_OFS_THR_LO)
		else $error("throttle trigger not shown");
	cur_scale_a: assert property (##1 charge_current_ma_o ==
		{6'h00, $past(field_q)} * chfs_pkg::CHFS_CUR_STEP_MA)
		else $error("current scaling wrong");
	cur_in_clear_a: assert property ($fell(ig_s) && !iov_s |=> field_q == 7'h00)
		else $error("setpoint not cleared on input loss");
	cur_pack_clear_a: assert property ($fell(pack_s) |=> field_q == 7'h00)
		else $error("setpoint not cleared on pack removal");
	cur_keep_a: assert property (!cur_clear && !wr_stb |=> $stable(field_q))
		else $error("setpoint changed without cause");
	cur_rsv_a: assert property (wr_stb && ptr_q == chfs_pkg::CHFS_OFS_CUR_HI
		&& shreg_q[7:5] != chfs_pkg::CHFS_CUR_HI_RSV_OK && !cur_clear
		|=> $stable(field_q))
		else $error("invalid high byte write took effect");

	cur_commit_c: cover property (cur_commit);
	fault_read_c: cover property (flt_rd_clr && flt_q != 3'h0);
	ovp_clear_c: cover property (ovp_flag ##1 !ovp_flag);

endmodule : chfs_regs

//--- rtl/chfs_pkg.sv
// Shared constants and types of the charger fault, status and charge current registers
package chfs_pkg;

	// ************************************************************
	// Target port
	// ************************************************************
	// Bus address of the target port; the value is arbitrary
	localparam logic [6:0] CHFS_DEV_ADDR = 7'h5A;
	// Bits in one byte on the two-wire bus
	localparam logic [3:0] CHFS_BYTE_BITS = 4'h8;

	// ************************************************************
	// Register byte addresses
	// ************************************************************
	localparam logic [7:0] CHFS_OFS_CUR_LO = 8'h02;
	localparam logic [7:0] CHFS_OFS_CUR_HI = 8'h03;
	localparam logic [7:0] CHFS_OFS_FAULT = 8'h20;
	localparam logic [7:0] CHFS_OFS_STAT_HI = 8'h21;
	localparam logic [7:0] CHFS_OFS_THR_LO = 8'h22;
	localparam logic [7:0] CHFS_OFS_THR_HI = 8'h23;

	// ************************************************************
	// Field positions and widths
	// ************************************************************
	localparam int CHFS_OVP_BIT = 4;
	localparam int CHFS_INPUT_GOOD_BIT = 7;
	localparam int CHFS_FAULT_W = 3;
	localparam int CHFS_THR_W = 7;
	localparam int CHFS_CUR_W = 7;
	localparam int CHFS_MA_W = 13;
	// Low byte carries field bits 1:0 at its top two bits
	localparam int CHFS_CUR_LO_LSB = 6;
	// High byte bits 7:5 must be zero for a valid write
	localparam logic [2:0] CHFS_CUR_HI_RSV_OK = 3'h0;

	// ************************************************************
	// Reset values and scaling
	// ************************************************************
	localparam logic [CHFS_CUR_W-1:0] CHFS_CUR_RESET = 7'h00;
	localparam logic [7:0] CHFS_BYTE_RESET = 8'h00;
	// Weight of field bit 0 in milliamps with the nominal sense resistor
	localparam logic [CHFS_MA_W-1:0] CHFS_CUR_STEP_MA = 13'h0040;

	// Target port sequencer states
	typedef enum logic [6:0] {
		CHFS_ST_IDLE = 7'h01,
		CHFS_ST_ADDR = 7'h02,
		CHFS_ST_AACK = 7'h04,
		CHFS_ST_WR = 7'h08,
		CHFS_ST_WACK = 7'h10,
		CHFS_ST_RD = 7'h20,
		CHFS_ST_RACK = 7'h40
	} chfs_state_t;

endpackage : chfs_pkg

//--- rtl/chfs_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
module chfs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// First stage feeds only the second stage
	always_comb
	begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;

endmodule : chfs_sync

//--- rtl/chfs_flag.sv
// Sticky status flag where a set in the clearing cycle wins
module chfs_flag (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic set_i,
	input wire logic clr_i,
	output logic flag_o
);

	logic flag_q;
	logic flag_d;

	// Set has priority so an event never slips past a clear
	always_comb
	begin
		flag_d = set_i | (flag_q & ~clr_i);
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

	assign flag_o = flag_q;

endmodule : chfs_flag

//--- test/chfs_host_model.sv
// Two-wire bus controller that stands in for the host embedded controller
module chfs_host_model (
	input wire logic mclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic hold_low_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus: clock high, data released to its pull-up
	initial
	begin
		scl_o = 1'b1;
		hold_low_o = 1'b0;
	end

	// Move both lines on a rising edge, then hold them for the rest of the phase
	task automatic step(input logic scl, input logic low, input int n);
		@(posedge mclk_i);
		scl_o <= scl;
		hold_low_o <= low;
		repeat (n - 1) @(posedge mclk_i);
	endtask : step

	// One bit: data changes only while the clock is low, sampled mid-high
	task automatic bit_io(input logic tx, output logic rx);
		step(1'b0, hold_low_o, 1);
		step(1'b0, !tx, 3);
		step(1'b1, !tx, 2);
		rx = sda_i;
		step(1'b1, !tx, 2);
	endtask : bit_io

	// Start or repeated start; lowering the clock first keeps data stable while it is high
	task automatic start();
		step(1'b0, hold_low_o, 1);
		step(1'b0, 1'b0, 3);
		step(1'b1, 1'b0, 4);
		step(1'b1, 1'b1, 4);
	endtask : start

	task automatic stop();
		step(1'b0, hold_low_o, 1);
		step(1'b0, 1'b1, 3);
		step(1'b1, 1'b1, 4);
		step(1'b1, 1'b0, 4);
	endtask : stop

	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic a9, output logic [7:0] rx,
		output logic s9);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(a9, s9);
	endtask : xfer

	task automatic wr(input logic [6:0] addr, input logic [7:0] ptr, input int n,
		input logic [15:0] data, output logic ok);
		logic [7:0] rx;
		logic s;
		start();
		xfer({addr, 1'b0}, 1'b1, rx, s);
		ok = !s;
		for (int i = -1; i < n && ok; i++)
		begin
			xfer((i < 0) ? ptr : data[8*i +: 8], 1'b1, rx, s);
			ok = ok & !s;
		end
		stop();
	endtask : wr

	// Pointer write, repeated start, then n bytes low first; the last byte is refused
	task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] data);
		logic [7:0] rx;
		logic s;
		data = 16'h0000;
		start();
		xfer({chfs_pkg::CHFS_DEV_ADDR, 1'b0}, 1'b1, rx, s);
		xfer(ptr, 1'b1, rx, s);
		start();
		xfer({chfs_pkg::CHFS_DEV_ADDR, 1'b1}, 1'b1, rx, s);
		for (int i = 0; i < n; i++)
		begin
			xfer(8'hFF, (i == n - 1), rx, s);
			data[8*i +: 8] = rx;
		end
		stop();
	endtask : rd
endmodule : chfs_host_model

//--- test/chfs_regs_tb.sv
// Self-checking bench for the charger fault, throttle status and setpoint registers
module chfs_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic scl, hold_low, sda_oe, sda_drv, en, ok;
	logic ovp = 1'b0, ig = 1'b1, iov = 1'b0, pp = 1'b1;
	logic [2:0] flt = 3'h0;
	logic [6:0] thr = 7'h00;
	logic [6:0] f;
	logic [12:0] ma;
	logic [15:0] rd16;
	logic [31:0] seed = 32'h0000_003D;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	// Open-drain data wire with a pull-up: low when either party pulls
	wire sda = !(hold_low | (sda_oe & !sda_drv));

	always #50 mclk_i = ~mclk_i;

	chfs_host_model host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .hold_low_o(hold_low));

	chfs_regs uut (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_drv),
		.sda_oe_o(sda_oe), .system_overvoltage_i(ovp), .power_path_latchoff_i(flt[2]),
		.reverse_mode_overvoltage_fault_i(flt[1]), .reverse_mode_overcurrent_fault_i(flt[0]),
		.comparator_trip_i(thr[6]), .critical_current_i(thr[5]), .nominal_current_i(thr[4]),
		.discharge_current_i(thr[3]), .system_voltage_i(thr[2]), .pack_removal_i(thr[1]),
		.source_removal_i(thr[0]), .input_good_i(ig), .input_overvoltage_i(iov),
		.cell_count_pack_present_i(pp), .converter_enable_o(en), .charge_current_ma_o(ma)
	);

	// Repeatable pseudo-random source
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	// Expected setpoint in mA as the sum of binary weights of the set field bits
	function automatic logic [15:0] exp_ma(input logic [6:0] v);
		exp_ma = 16'h0000;
		for (int i = 0; i < 7; i++)
			if (v[i])
				exp_ma = exp_ma + (16'h0040 << i);
	endfunction : exp_ma

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : idle

	task automatic print_verdict();
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// Reserved low-byte bits carry noise that the device must ignore
	task automatic put(input logic [6:0] v);
		seed = xs(seed);
		host.wr(chfs_pkg::CHFS_DEV_ADDR, 8'h02, 2, {3'h0, v, seed[5:0]}, ok);
		check("wr_ack", {15'h0000, ok}, 16'h0001);
		idle(4);
		check("ma", {3'h0, ma}, exp_ma(v));
	endtask : put

	// Hang guard: a full run needs well under half this many cycles
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			failures++;
			print_verdict();
		end
	end

	// Main sequence
	initial
	begin
		idle(12);
		check("ma_rst", {3'h0, ma}, 16'h0000);
		rstn_i <= 1'b1;
		idle(8);
		check("en_idle", {15'h0000, en}, 16'h0001);
		host.rd(8'h20, 2, rd16);
		check("status", rd16, 16'h8000);
		host.rd(8'h22, 2, rd16);
		check("thr_rst", rd16, 16'h0000);
		host.rd(8'h02, 2, rd16);
		check("cur_rst", rd16, 16'h0000);
		host.rd(8'h40, 1, rd16);
		check("unmapped", rd16, 16'h0000);
		host.wr(chfs_pkg::CHFS_DEV_ADDR ^ 7'h01, 8'h02, 2, 16'hFFC0, ok);
		check("bad_addr", {15'h0000, ok}, 16'h0000);
		// Boundary fields first, then random ones, each read back
		for (int k = 0; k < 6; k++)
		begin
			seed = xs(seed);
			f = (k == 0) ? 7'h7F : (k == 1) ? 7'h01 : seed[6:0];
			put(f);
			host.rd(8'h02, 2, rd16);
			check("cur_rb", {6'h00, rd16[15:6]}, {9'h000, f});
		end
		host.wr(chfs_pkg::CHFS_DEV_ADDR, 8'h02, 2, 16'hBF40, ok);
		idle(4);
		check("ma_invalid", {3'h0, ma}, exp_ma(f));
		// Input good falling under input overvoltage keeps the setpoint
		iov <= 1'b1;
		idle(2);
		ig <= 1'b0;
		idle(10);
		check("ma_iov", {3'h0, ma}, exp_ma(f));
		ig <= 1'b1;
		iov <= 1'b0;
		idle(10);
		// Overvoltage latch: set, persists, survives a write of one, cleared by zero
		ovp <= 1'b1;
		flt[2] <= 1'b1;
		idle(10);
		check("en_ovp", {15'h0000, en}, 16'h0000);
		check("ma_ovp", {3'h0, ma}, exp_ma(f));
		ovp <= 1'b0;
		flt[2] <= 1'b0;
		idle(10);
		check("en_latch", {15'h0000, en}, 16'h0000);
		host.rd(8'h20, 1, rd16);
		check("ovp_flag", rd16, 16'h0014);
		host.wr(chfs_pkg::CHFS_DEV_ADDR, 8'h20, 1, 16'h00FF, ok);
		idle(4);
		check("en_wr1", {15'h0000, en}, 16'h0000);
		host.rd(8'h20, 1, rd16);
		check("ovp_keep", rd16, 16'h0010);
		host.wr(chfs_pkg::CHFS_DEV_ADDR, 8'h20, 1, 16'h0000, ok);
		idle(4);
		check("en_wr0", {15'h0000, en}, 16'h0001);
		// Adapter removal clears both the latch and the setpoint
		ovp <= 1'b1;
		idle(10);
		ovp <= 1'b0;
		ig <= 1'b0;
		idle(10);
		check("ma_ig", {3'h0, ma}, 16'h0000);
		ig <= 1'b1;
		idle(10);
		check("en_unplug", {15'h0000, en}, 16'h0001);
		put(7'h55);
		pp <= 1'b0;
		idle(10);
		check("ma_pack", {3'h0, ma}, 16'h0000);
		pp <= 1'b1;
		// Mid-run reset drops a programmed setpoint back to zero
		put(7'h2A);
		rstn_i <= 1'b0;
		idle(12);
		check("ma_rst2", {3'h0, ma}, 16'h0000);
		rstn_i <= 1'b1;
		idle(8);
		host.rd(8'h02, 2, rd16);
		check("cur_rst2", rd16, 16'h0000);
		// Latched faults and throttle flags read once, then read clear
		for (int k = 0; k < 4; k++)
		begin
			seed = xs(seed);
			host.wr(chfs_pkg::CHFS_DEV_ADDR, 8'h22, 2, 16'hFFFF, ok);
			flt <= (k == 0) ? 3'h7 : seed[2:0];
			thr <= (k == 0) ? 7'h7F : seed[14:8];
			idle(4);
			flt <= 3'h0;
			thr <= 7'h00;
			idle(10);
			host.rd(8'h20, 1, rd16);
			check("fault", rd16, {13'h0000, (k == 0) ? 3'h7 : seed[2:0]});
			host.rd(8'h20, 1, rd16);
			check("fault_clr", rd16, 16'h0000);
			host.rd(8'h22, 2, rd16);
			check("thr", rd16, {9'h000, (k == 0) ? 7'h7F : seed[14:8]});
			host.rd(8'h22, 2, rd16);
			check("thr_clr", rd16, 16'h0000);
		end
		print_verdict();
	end
endmodule : chfs_regs_tb
